/* core/nsrom_pkg.sv */
// shared constants and types for the nibble serial speech rom port
package nsrom_pkg;
  localparam int ADDR_W = 16;
  localparam int WORD_W = 16;
  localparam int NIB_W = 4;
  localparam int CHIP_SEL_W = 2;
  localparam int LOCAL_W = 14;
  localparam int DEPTH = 16384;
  localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
  localparam logic [1:0] NIB_IDX_RST = 2'h0;
  localparam logic [1:0] CHIP_ID_RST = 2'h0;
  // pin filter idle levels: clear, enable, strobe, select and mode high
  localparam logic [9:0] PIN_SYNC_RST = 10'h03e;
  // address-load, pointer-fetch and ready states
  typedef enum logic [1:0] {
    NSROM_LOAD = 2'b00,
    NSROM_PTR_FETCH = 2'b01,
    NSROM_READY = 2'b10
  } nsrom_state_e;
  // addressing modes
  typedef enum logic [1:0] {
    NSROM_DIRECT16 = 2'b00,
    NSROM_INDIRECT16 = 2'b01,
    NSROM_INDIRECT8 = 2'b10
  } nsrom_mode_e;
endpackage

/* core/nsrom_sync.sv */
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module nsrom_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] s1_q; // first stage, read only by s2
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  // one generate slice per bit
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    // shift chain, output moves once stages two and three agree
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        s1_q[i] <= RST_VAL[i];
        s2_q[i] <= RST_VAL[i];
        s3_q[i] <= RST_VAL[i];
        sync_out[i] <= RST_VAL[i];
      end else if (ce) begin
        s1_q[i] <= async_in[i];
        s2_q[i] <= s1_q[i];
        s3_q[i] <= s2_q[i];
        if (s2_q[i] == s3_q[i]) begin
          sync_out[i] <= s3_q[i];
        end
      end
    end
  end
endmodule

/* core/nsrom_port.sv */
// device side of the nibble serial speech rom port
// How it works
// - clear low initialises, bus undriven
// - chip enable high floats nibble bus
// - write-select strobe latches next address nibble
// - read-select strobe drives addressed data nibble
// - bus bit 0 is lsb
// - mode pin sampled at nibbles two, four
// - mode decode: direct, indirect16, indirect8
// - high at nibble two ends load, 8-bit
// - later nibbles start a fresh address
// - top two bits select chip, 14 word
// - indirect modes fetch pointer word first
// - clear pulse resets pointer, load state, enable
// - logic runs from clk, stepping on host rom clock rises
`timescale 1ns/1ps
module nsrom_port #(
  parameter logic [1:0] CHIP_ID = nsrom_pkg::CHIP_ID_RST // position among parallel roms
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic rom_clock_in,
  input wire logic hardware_clear_n,
  input wire logic chip_enable_n,
  input wire logic transfer_strobe_n,
  input wire logic read_select,
  input wire logic address_mode_pin,
  input wire logic [3:0] nibble_in,
  output logic [3:0] nibble_out,
  output logic nibble_oe,
  output logic [nsrom_pkg::ADDR_W-1:0] data_pointer,
  output logic addr_loaded,
  input wire logic rom_load_en,
  input wire logic [nsrom_pkg::LOCAL_W-1:0] rom_load_addr,
  input wire logic [nsrom_pkg::WORD_W-1:0] rom_load_data
);
  // synchronised pin levels
  logic clk_s, clr_n_s, ce_n_s, str_n_s, rd_s, mode_s;
  logic [3:0] nib_s;
  logic rck_prev_q; // previous rom clock level
  logic str_prev_q; // previous strobe level, sampled on rom clock
  logic rck_rise;
  logic str_fall;
  nsrom_pkg::nsrom_state_e state_q;
  nsrom_pkg::nsrom_mode_e mode_q;
  logic [1:0] nib_cnt_q; // address nibble position
  logic mode2_q; // mode pin at nibble two
  logic [nsrom_pkg::ADDR_W-1:0] addr_q; // assembled address
  logic [nsrom_pkg::ADDR_W-1:0] ptr_q; // data pointer
  logic [1:0] rd_nib_q; // data nibble position
  logic chip_en_q; // internal chip enable
  logic [nsrom_pkg::WORD_W-1:0] mem_q [nsrom_pkg::DEPTH]; // rom words
  logic [nsrom_pkg::WORD_W-1:0] cur_word;
  logic [nsrom_pkg::WORD_W-1:0] ptr_word;
  logic selected;

  // all pins pass the three-stage filter
  nsrom_sync #(.WIDTH(10), .RST_VAL(nsrom_pkg::PIN_SYNC_RST)) u_sync (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .async_in({nibble_in, address_mode_pin, read_select, transfer_strobe_n,
               chip_enable_n, hardware_clear_n, rom_clock_in}),
    .sync_out({nib_s, mode_s, rd_s, str_n_s, ce_n_s, clr_n_s, clk_s})
  );

  // rom clock edge finder
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rck_prev_q <= 1'b0;
    end else if (ce) begin
      rck_prev_q <= clk_s;
    end
  end
  assign rck_rise = clk_s && !rck_prev_q;

  // strobe is watched only on rom clock rises
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      str_prev_q <= 1'b1;
    end else if (ce && rck_rise) begin
      str_prev_q <= str_n_s;
    end
  end
  assign str_fall = rck_rise && str_prev_q && !str_n_s;

  // word lookups, 14 local address bits
  assign cur_word = mem_q[ptr_q[nsrom_pkg::LOCAL_W-1:0]];
  assign ptr_word = mem_q[addr_q[nsrom_pkg::LOCAL_W-1:0]];
  // top two pointer bits pick the responding chip
  assign selected = (ptr_q[nsrom_pkg::ADDR_W-1 -: nsrom_pkg::CHIP_SEL_W] == CHIP_ID);

  // preload port for the rom contents
  always_ff @(posedge clk) begin
    if (ce && rom_load_en) begin // frozen with the rest while ce is low
      mem_q[rom_load_addr] <= rom_load_data;
    end
  end

  // address assembly, mode decode and pointer fetch
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= nsrom_pkg::NSROM_LOAD;
      mode_q <= nsrom_pkg::NSROM_DIRECT16;
      nib_cnt_q <= nsrom_pkg::NIB_IDX_RST;
      mode2_q <= 1'b0;
      addr_q <= nsrom_pkg::ADDR_RST;
      ptr_q <= nsrom_pkg::ADDR_RST;
      rd_nib_q <= nsrom_pkg::NIB_IDX_RST;
      chip_en_q <= 1'b0;
    end else if (ce) begin
      if (!clr_n_s) begin
        // clear: pointer, load state and enable reset
        state_q <= nsrom_pkg::NSROM_LOAD;
        nib_cnt_q <= nsrom_pkg::NIB_IDX_RST;
        addr_q <= nsrom_pkg::ADDR_RST;
        ptr_q <= nsrom_pkg::ADDR_RST;
        rd_nib_q <= nsrom_pkg::NIB_IDX_RST;
        chip_en_q <= 1'b0;
      end else begin
        case (state_q)
          nsrom_pkg::NSROM_PTR_FETCH: begin
            // pointer lookup on the next rom clock rise
            if (rck_rise) begin
              ptr_q <= ptr_word;
              rd_nib_q <= nsrom_pkg::NIB_IDX_RST;
              chip_en_q <= 1'b1;
              state_q <= nsrom_pkg::NSROM_READY;
            end
          end
          default: begin
            if (str_fall && !rd_s) begin
              // write strobe: one nibble, lsb in bit 0
              case (nib_cnt_q)
                2'h0: begin
                  addr_q <= {12'h000, nib_s};
                  nib_cnt_q <= 2'h1;
                  state_q <= nsrom_pkg::NSROM_LOAD;
                  chip_en_q <= 1'b0;
                end
                2'h1: begin
                  addr_q[7:4] <= nib_s;
                  mode2_q <= mode_s;
                  if (mode_s) begin
                    // 8-bit indirect: high byte zero, done
                    addr_q[15:8] <= 8'h00;
                    mode_q <= nsrom_pkg::NSROM_INDIRECT8;
                    nib_cnt_q <= 2'h0;
                    state_q <= nsrom_pkg::NSROM_PTR_FETCH;
                  end else begin
                    nib_cnt_q <= 2'h2;
                  end
                end
                2'h2: begin
                  addr_q[11:8] <= nib_s;
                  nib_cnt_q <= 2'h3;
                end
                default: begin
                  addr_q[15:12] <= nib_s;
                  nib_cnt_q <= 2'h0;
                  if (mode_s) begin
                    // low then high: 16-bit indirect
                    mode_q <= nsrom_pkg::NSROM_INDIRECT16;
                    state_q <= nsrom_pkg::NSROM_PTR_FETCH;
                  end else begin
                    // low then low: address is pointer
                    mode_q <= nsrom_pkg::NSROM_DIRECT16;
                    ptr_q <= {nib_s, addr_q[11:0]};
                    rd_nib_q <= nsrom_pkg::NIB_IDX_RST;
                    chip_en_q <= 1'b1;
                    state_q <= nsrom_pkg::NSROM_READY;
                  end
                end
              endcase
            end else if (str_fall && rd_s) begin
              // a read strobe outside pointer fetch restarts address assembly, so a dummy
              // nibble followed by a dummy read cannot skew the next load
              nib_cnt_q <= nsrom_pkg::NIB_IDX_RST;
              if (state_q == nsrom_pkg::NSROM_READY) begin
                // read strobe: step nibble, then word
                rd_nib_q <= rd_nib_q + 2'h1;
                if (rd_nib_q == 2'h3) begin
                  ptr_q <= ptr_q + 16'h0001;
                end
              end
            end
          end
        endcase
      end
    end
  end

  // data nibble register, lsb nibble first
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      nibble_out <= 4'h0;
    end else if (ce && str_fall && rd_s) begin
      nibble_out <= cur_word[rd_nib_q*4 +: 4];
    end
  end

  // drivers: clear and chip enable override all
  assign nibble_oe = clr_n_s && !ce_n_s && !str_n_s && rd_s && chip_en_q
                     && selected;
  assign data_pointer = ptr_q;
  assign addr_loaded = (state_q == nsrom_pkg::NSROM_READY);

  // clear low keeps the bus undriven
  a_clear_floats: assert property (
    @(posedge clk) disable iff (rst) !clr_n_s |-> !nibble_oe)
    else $error("bus driven during clear");
  // chip enable high keeps the bus undriven
  a_ce_floats: assert property (
    @(posedge clk) disable iff (rst) ce_n_s |-> !nibble_oe)
    else $error("bus driven with chip disabled");
  // clear returns pointer, load state and enable
  a_clear_resets: assert property (
    @(posedge clk) disable iff (rst) (ce && !clr_n_s) |=>
    (state_q == nsrom_pkg::NSROM_LOAD && ptr_q == nsrom_pkg::ADDR_RST && !chip_en_q))
    else $error("clear did not reset");
  // mode high at nibble two ends an 8-bit load
  a_ind8_end: assert property (
    @(posedge clk) disable iff (rst)
    (ce && clr_n_s && str_fall && !rd_s && nib_cnt_q == 2'h1 && mode_s
    && state_q != nsrom_pkg::NSROM_PTR_FETCH) |=> (nib_cnt_q == 2'h0
    && addr_q[15:8] == 8'h00 && mode_q == nsrom_pkg::NSROM_INDIRECT8))
    else $error("8-bit indirect load wrong");
  // first write nibble lands in the low bits
  a_nib_capture: assert property (
    @(posedge clk) disable iff (rst)
    (ce && clr_n_s && str_fall && !rd_s && nib_cnt_q == 2'h0
    && state_q != nsrom_pkg::NSROM_PTR_FETCH) |=> (addr_q[3:0] == $past(nib_s)
    && nib_cnt_q == 2'h1))
    else $error("first nibble not captured");
  // a new first nibble drops the old address and the old pointer's drive
  a_fresh_addr: assert property (
    @(posedge clk) disable iff (rst)
    (ce && clr_n_s && str_fall && !rd_s && nib_cnt_q == 2'h0
    && state_q != nsrom_pkg::NSROM_PTR_FETCH) |=> (addr_q[15:4] == 12'h000
    && !addr_loaded))
    else $error("old address survived");
  // low then low makes the address the pointer
  a_direct_ptr: assert property (
    @(posedge clk) disable iff (rst)
    (ce && clr_n_s && str_fall && !rd_s && nib_cnt_q == 2'h3 && !mode_s
    && state_q != nsrom_pkg::NSROM_PTR_FETCH) |=> (ptr_q == {$past(nib_s),
    $past(addr_q[11:0])} && addr_loaded))
    else $error("direct pointer wrong");
  // low then high starts a 16-bit pointer fetch
  a_ind16_fetch: assert property (
    @(posedge clk) disable iff (rst)
    (ce && clr_n_s && str_fall && !rd_s && nib_cnt_q == 2'h3 && mode_s
    && state_q != nsrom_pkg::NSROM_PTR_FETCH) |=> (state_q == nsrom_pkg::NSROM_PTR_FETCH
    && mode_q == nsrom_pkg::NSROM_INDIRECT16))
    else $error("16-bit indirect load wrong");
  // a loaded 16-bit indirect address saw mode low at nibble two
  a_mode_track: assert property (
    @(posedge clk) disable iff (rst)
    (addr_loaded && mode_q == nsrom_pkg::NSROM_INDIRECT16) |-> !mode2_q)
    else $error("mode pin history lost");
  // pointer fetch ends within 40 clocks
  a_fetch_bound: assert property (
    @(posedge clk) disable iff (rst)
    (state_q == nsrom_pkg::NSROM_PTR_FETCH && ce) |-> ##[1:40]
    (state_q != nsrom_pkg::NSROM_PTR_FETCH))
    else $error("pointer fetch stuck");
  // fetched table word becomes the pointer, reads start at nibble zero
  a_ptr_load: assert property (
    @(posedge clk) disable iff (rst)
    (ce && clr_n_s && rck_rise && state_q == nsrom_pkg::NSROM_PTR_FETCH) |=>
    (ptr_q == $past(ptr_word) && addr_loaded && rd_nib_q == 2'h0))
    else $error("pointer not fetched");
  // read strobes step the nibble position
  a_read_step: assert property (
    @(posedge clk) disable iff (rst)
    (ce && clr_n_s && str_fall && rd_s && addr_loaded) |=>
    (rd_nib_q == $past(rd_nib_q) + 2'h1))
    else $error("nibble did not advance");
  // the fourth read moves to the next word
  a_word_step: assert property (
    @(posedge clk) disable iff (rst)
    (ce && clr_n_s && str_fall && rd_s && addr_loaded && rd_nib_q == 2'h3) |=>
    (ptr_q == $past(ptr_q) + 16'h0001))
    else $error("pointer did not step");
  // first read of a word returns its low nibble
  a_low_nibble: assert property (
    @(posedge clk) disable iff (rst)
    (ce && str_fall && rd_s && rd_nib_q == 2'h0) |=> (nibble_out == $past(cur_word[3:0])))
    else $error("low nibble not first");
  // read strobes leave the address alone and restart assembly
  a_read_no_addr: assert property (
    @(posedge clk) disable iff (rst)
    (ce && clr_n_s && str_fall && rd_s && state_q != nsrom_pkg::NSROM_PTR_FETCH) |=>
    ($stable(addr_q) && nib_cnt_q == 2'h0))
    else $error("read strobe disturbed address");
  // the bus is driven only once an address is complete
  a_oe_loaded: assert property (
    @(posedge clk) disable iff (rst) nibble_oe |-> addr_loaded)
    else $error("bus driven before load");
  // state moves only on a rom clock rise or under clear
  a_strobe_rck: assert property (
    @(posedge clk) disable iff (rst)
    (ce && clr_n_s && !rck_rise) |=> ($stable(nib_cnt_q) && $stable(ptr_q)
    && $stable(state_q)))
    else $error("state moved off rom clock");

  c_direct: cover property (@(posedge clk) disable iff (rst)
    addr_loaded && mode_q == nsrom_pkg::NSROM_DIRECT16);
  c_ind16: cover property (@(posedge clk) disable iff (rst)
    addr_loaded && mode_q == nsrom_pkg::NSROM_INDIRECT16);
  c_ind8: cover property (@(posedge clk) disable iff (rst)
    addr_loaded && mode_q == nsrom_pkg::NSROM_INDIRECT8);
  c_word_step: cover property (@(posedge clk) disable iff (rst)
    str_fall && rd_s && rd_nib_q == 2'h3 && addr_loaded);
endmodule

/* verification/nsrom_host.sv */
// host processor model driving the rom port pins
`timescale 1ns/1ps
module nsrom_host (
  input wire logic clk,
  output logic rom_clock_in,
  output logic transfer_strobe_n,
  output logic read_select,
  output logic address_mode_pin,
  output logic [3:0] nibble_bus,
  input wire logic [3:0] nibble_out,
  input wire logic nibble_oe
);
  logic drv; // host drives the bus
  logic [3:0] hval; // value the host drives
  logic [3:0] last_q = 4'h0; // last driven bus level
  // free running rom clock, phase unrelated to clk
  initial begin
    rom_clock_in = 1'b0;
    #37;
    forever #62.5 rom_clock_in = ~rom_clock_in;
  end
  // idle pins: strobe and direction high
  initial begin
    transfer_strobe_n = 1'b1;
    read_select = 1'b1;
    address_mode_pin = 1'b0;
    drv = 1'b0;
    hval = 4'h0;
  end
  // wire level; an undriven bus shows the inverse of its last level
  always_comb begin
    if (nibble_oe) begin
      nibble_bus = nibble_out;
    end else if (drv) begin
      nibble_bus = hval;
    end else begin
      nibble_bus = ~last_q;
    end
  end
  // remember the last driven level
  always @(posedge clk) begin
    if (drv || nibble_oe) begin
      last_q <= nibble_bus;
    end
  end
  // one strobe pulse held across a rom clock rise, bus sampled while low
  task automatic xfer(input logic rs, input logic md, input logic [3:0] v,
                      output logic [3:0] got, output logic oe_seen);
    @(posedge rom_clock_in);
    @(negedge clk);
    read_select = rs;
    address_mode_pin = md;
    hval = v;
    drv = ~rs;
    transfer_strobe_n = 1'b0;
    @(posedge rom_clock_in);
    repeat (8) @(negedge clk);
    got = nibble_bus;
    oe_seen = nibble_oe;
    transfer_strobe_n = 1'b1;
    drv = 1'b0;
    @(posedge rom_clock_in);
    repeat (8) @(negedge clk);
  endtask
  // address nibbles lsb first; mode high at nibble two stops after two
  task automatic load_addr(input logic [15:0] a, input logic m2, input logic m4);
    logic [3:0] g;
    logic o;
    xfer(1'b0, 1'b0, a[3:0], g, o);
    xfer(1'b0, m2, a[7:4], g, o);
    if (!m2) begin
      xfer(1'b0, 1'b0, a[11:8], g, o);
      xfer(1'b0, m4, a[15:12], g, o);
    end
  endtask
  // dummy address load then dummy read before a valid load
  task automatic start_up();
    logic [3:0] g;
    logic o;
    xfer(1'b0, 1'b0, 4'h0, g, o);
    xfer(1'b1, 1'b0, 4'h0, g, o);
  endtask
endmodule

/* verification/nsrom_port_tb.sv */
// self-checking bench for the nibble serial speech rom port
`timescale 1ns/1ps
module nsrom_port_tb;
  logic clk, rst, ce, hardware_clear_n, chip_enable_n, rom_load_en; // bench driven
  logic rom_clock_in, transfer_strobe_n, read_select, address_mode_pin; // host pins
  logic nibble_oe, addr_loaded; // device flags
  logic [3:0] nibble_bus, nibble_out; // bus wire and data
  logic [15:0] data_pointer, rom_load_data; // pointer and preload word
  logic [13:0] rom_load_addr; // preload address
  int err_total, checks; // counters
  nsrom_port dut (.clk(clk), .rst(rst), .ce(ce), .rom_clock_in(rom_clock_in),
    .hardware_clear_n(hardware_clear_n), .chip_enable_n(chip_enable_n),
    .transfer_strobe_n(transfer_strobe_n), .read_select(read_select),
    .address_mode_pin(address_mode_pin), .nibble_in(nibble_bus),
    .nibble_out(nibble_out), .nibble_oe(nibble_oe), .data_pointer(data_pointer),
    .addr_loaded(addr_loaded), .rom_load_en(rom_load_en),
    .rom_load_addr(rom_load_addr), .rom_load_data(rom_load_data));
  nsrom_host host (.clk(clk), .rom_clock_in(rom_clock_in),
    .transfer_strobe_n(transfer_strobe_n), .read_select(read_select),
    .address_mode_pin(address_mode_pin), .nibble_bus(nibble_bus),
    .nibble_out(nibble_out), .nibble_oe(nibble_oe));
  // 100 mhz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // preload one rom word
  task automatic put_word(input logic [13:0] a, input logic [15:0] d);
    @(negedge clk);
    rom_load_en = 1'b1;
    rom_load_addr = a;
    rom_load_data = d;
    @(negedge clk);
    rom_load_en = 1'b0;
  endtask
  // one read strobe; drive flag always checked, data only when driven
  task automatic rd(input logic [3:0] en, input logic eo);
    logic [3:0] g;
    logic o;
    host.xfer(1'b1, 1'b0, 4'h0, g, o);
    chk({15'h0, o}, {15'h0, eo});
    if (eo) chk({12'h0, g}, {12'h0, en});
  endtask
  // direct load then eight reads across two words
  task automatic t_direct();
    host.start_up();
    host.load_addr(16'h0100, 1'b0, 1'b0);
    chk({15'h0, addr_loaded}, 16'h0001);
    chk(data_pointer, 16'h0100);
    for (int i = 1; i < 9; i++) rd(i[3:0], 1'b1);
    chk(data_pointer, 16'h0102);
    $display("t_direct done");
  endtask
  // clear pulse drops pointer, loaded state and drive
  task automatic t_clear();
    @(negedge clk);
    hardware_clear_n = 1'b0;
    rd(4'h0, 1'b0);
    @(negedge clk);
    hardware_clear_n = 1'b1;
    repeat (8) @(negedge clk);
    chk(data_pointer, 16'h0000);
    chk({15'h0, addr_loaded}, 16'h0000);
    rd(4'h0, 1'b0);
    $display("t_clear done");
  endtask
  // 16-bit indirect: pointer fetched from table word
  task automatic t_ind16();
    host.start_up();
    host.load_addr(16'h0201, 1'b0, 1'b1);
    chk(data_pointer, 16'h0100);
    rd(4'h1, 1'b1);
    $display("t_ind16 done");
  endtask
  // 8-bit indirect ends at two nibbles, later nibbles start afresh
  task automatic t_ind8();
    host.load_addr(16'h0042, 1'b1, 1'b0);
    chk(data_pointer, 16'h0101);
    rd(4'h5, 1'b1);
    host.load_addr(16'h0000, 1'b0, 1'b0);
    chk(data_pointer, 16'h0000);
    rd(4'h2, 1'b1);
    $display("t_ind8 done");
  endtask
  // chip enable high and foreign chip bits both keep the bus free
  task automatic t_cs();
    @(negedge clk);
    chip_enable_n = 1'b1;
    rd(4'h0, 1'b0);
    @(negedge clk);
    chip_enable_n = 1'b0;
    host.load_addr(16'h4000, 1'b0, 1'b0);
    chk(data_pointer, 16'h4000);
    rd(4'h0, 1'b0);
    $display("t_cs done");
  endtask
  // verdict and end of run
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    err_total = 0;
    checks = 0;
    rst = 1'b1;
    ce = 1'b1;
    hardware_clear_n = 1'b1;
    chip_enable_n = 1'b0;
    rom_load_en = 1'b0;
    rom_load_addr = 14'h0;
    rom_load_data = 16'h0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    put_word(14'h0000, 16'h05a2);
    put_word(14'h0100, 16'h4321);
    put_word(14'h0101, 16'h8765);
    put_word(14'h0201, 16'h0100);
    put_word(14'h0042, 16'h0101);
    repeat (5) @(negedge clk);
    t_direct();
    t_clear();
    t_ind16();
    t_ind8();
    t_cs();
    end_sim();
  end
  // watchdog well past the expected run of some 14 us
  initial begin
    #200000;
    err_total++;
    end_sim();
  end
endmodule
